// *** rtl/tsr_regs.vh ***
// constants for the toggling set/clear storage cell
//
// Contract
// - trigger rising edge inverts output when idle
// - set or clear high masks the trigger
// - effective set drives output high
// - effective clear drives output low
// - priority select decides when both high
// - next output from inputs and previous output
// - plain latch: no trigger, clear dominates
// - retentive mode restores output after power loss
// - non-retentive mode clears output after power loss
// - trigger low with clear priority equals latch
`ifndef TSR_REGS_VH
`define TSR_REGS_VH

// stored output value after reset and after a non-retentive power return
`define TSR_Q_RESET 1'h0

// encoding of the priority select input
`define TSR_PRIO_CLEAR_DOMINANT 1'h0
`define TSR_PRIO_FORCE_HIGH_DOMINANT 1'h1

// encoding of the mode select input
`define TSR_MODE_TOGGLE 1'h0
`define TSR_MODE_PLAIN_LATCH 1'h1

// power sequencer state codes
`define TSR_ST_OFF 2'h0
`define TSR_ST_RESTORE 2'h1
`define TSR_ST_RUN 2'h2

// cycles the restore state lasts before normal evaluation resumes
`define TSR_RESTORE_CYCLES 2'h1

`endif

// *** rtl/tsr_edge.v ***
// registered edge detector for one synchronous level
`timescale 1ns/1ps
`default_nettype none

module tsr_edge #(
  parameter [0:0] INIT = 1'h0
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // sampled level
  input wire level_i,
  // edge results
  output wire rise_o,
  output wire fall_o,
  output wire prev_o
);

  reg level_prev_r;

  // keep last cycle's sample so each cycle compares now against before
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_prev_r <= INIT;
    end else begin
      level_prev_r <= level_i;
    end
  end

  // a rise is high now and low one cycle ago
  assign rise_o = level_i & ~level_prev_r;
  assign fall_o = ~level_i & level_prev_r;
  assign prev_o = level_prev_r;

endmodule // tsr_edge

`default_nettype wire

// *** rtl/tsr_top.v ***
// toggling set/clear storage cell with priority select and retention
`timescale 1ns/1ps
`default_nettype none
`include "tsr_regs.vh"

module tsr_top (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // logic inputs from other blocks
  input wire trg_i,
  input wire set_i,
  input wire clear_i,
  // configuration
  input wire prio_sel_i,
  input wire mode_sel_i,
  input wire retain_en_i,
  // supply state, high while powered
  input wire power_ok_i,
  // stored output
  output wire q_o,
  output wire q_n_o,
  // status
  output wire running_o,
  output wire toggled_o,
  output wire trg_ignored_o,
  output wire conflict_o,
  output wire restored_o
);

  localparam [1:0] ST_OFF = `TSR_ST_OFF;
  localparam [1:0] ST_RESTORE = `TSR_ST_RESTORE;
  localparam [1:0] ST_RUN = `TSR_ST_RUN;

  // reset synchroniser
  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n;

  // sequencer state
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] restore_cnt_r;
  reg [1:0] restore_cnt_nxt;

  // stored value and the copy kept across supply loss
  reg q_r;
  reg q_nxt;
  reg q_saved_r;
  reg q_saved_nxt;

  // status pulses
  reg toggled_r;
  reg toggled_nxt;
  reg trg_ignored_r;
  reg trg_ignored_nxt;
  reg conflict_r;
  reg conflict_nxt;
  reg restored_r;
  reg restored_nxt;

  // decode
  wire trg_rise;
  wire pwr_rise;
  wire pwr_fall;
  reg plain_mode;
  reg clear_wins;
  wire trg_gated;
  reg set_eff;
  reg clear_eff;
  reg both_high;
  wire run_eval;

  // release reset through two flops; assertion stays asynchronous
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'h0;
      rst_sync_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // trigger edge from current sample against the previous one
  tsr_edge #(
    .INIT (1'h0)
  ) u_trg_edge (
    .clk_i (clk_i),
    .rst_n_i (rst_n),
    .level_i (trg_i),
    .rise_o (trg_rise),
    .fall_o (),
    .prev_o ()
  );

  // supply edges start and stop the evaluation
  tsr_edge #(
    .INIT (1'h0)
  ) u_pwr_edge (
    .clk_i (clk_i),
    .rst_n_i (rst_n),
    .level_i (power_ok_i),
    .rise_o (pwr_rise),
    .fall_o (pwr_fall),
    .prev_o ()
  );

  // plain latch mode forces clear priority and drops the trigger
  always @* begin
    plain_mode = 1'h0;
    clear_wins = 1'h1;
    case (mode_sel_i)
      `TSR_MODE_TOGGLE: begin
        plain_mode = 1'h0;
        clear_wins = (prio_sel_i == `TSR_PRIO_CLEAR_DOMINANT);
      end
      `TSR_MODE_PLAIN_LATCH: begin
        plain_mode = 1'h1;
        clear_wins = 1'h1;
      end
      default: begin
        plain_mode = 1'h0;
        clear_wins = 1'h1;
      end
    endcase
  end

  // a masked edge must never reach the toggle path
  assign trg_gated = trg_rise & ~plain_mode;

  // priority resolution: only one of set and clear is ever effective
  always @* begin
    set_eff = 1'h0;
    clear_eff = 1'h0;
    both_high = 1'h0;
    case ({set_i, clear_i})
      2'h0: begin
        // neither level up; the trigger may act
        set_eff = 1'h0;
      end
      2'h1: begin
        clear_eff = 1'h1;
      end
      2'h2: begin
        set_eff = 1'h1;
      end
      2'h3: begin
        // both up: the priority select, or latch mode, names the winner
        both_high = 1'h1;
        if (clear_wins) begin
          clear_eff = 1'h1;
        end else begin
          set_eff = 1'h1;
        end
      end
      default: begin
        both_high = 1'h0;
      end
    endcase
  end

  // evaluation happens only while powered and past the restore step
  assign run_eval = (state_r == ST_RUN) & power_ok_i;

  // power sequencer
  always @* begin
    state_nxt = state_r;
    restore_cnt_nxt = restore_cnt_r;
    case (state_r)
      ST_OFF: begin
        if (pwr_rise) begin
          state_nxt = ST_RESTORE;
          restore_cnt_nxt = `TSR_RESTORE_CYCLES;
        end
      end
      ST_RESTORE: begin
        if (!power_ok_i) begin
          state_nxt = ST_OFF;
        end else if (restore_cnt_r == 2'h1) begin
          state_nxt = ST_RUN;
          restore_cnt_nxt = 2'h0;
        end else begin
          restore_cnt_nxt = restore_cnt_r - 2'h1;
        end
      end
      ST_RUN: begin
        if (pwr_fall || !power_ok_i) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
        restore_cnt_nxt = 2'h0;
      end
    endcase
  end

  // next stored value; clear checked first, set second, trigger last
  always @* begin
    q_nxt = q_r; // hold when nothing demands a change
    q_saved_nxt = q_saved_r;
    case (state_r)
      ST_OFF: begin
        // output dark while unpowered; saved copy keeps the last value
        q_nxt = `TSR_Q_RESET;
      end
      ST_RESTORE: begin
        if (power_ok_i) begin
          if (retain_en_i) begin
            q_nxt = q_saved_r;
          end else begin
            q_nxt = `TSR_Q_RESET;
            q_saved_nxt = `TSR_Q_RESET;
          end
        end else begin
          q_nxt = `TSR_Q_RESET;
        end
      end
      ST_RUN: begin
        if (run_eval) begin
          if (clear_eff) begin
            q_nxt = 1'h0;
          end else if (set_eff) begin
            q_nxt = 1'h1;
          end else if (trg_gated) begin
            q_nxt = ~q_r;
          end
          // track the live value so a later loss of supply can restore it
          q_saved_nxt = q_nxt;
        end else begin
          // supply dropped this cycle: freeze saved copy, darken output
          q_nxt = `TSR_Q_RESET;
        end
      end
      default: begin
        q_nxt = `TSR_Q_RESET;
      end
    endcase
  end

  // status pulses, each standing for the one cycle after its evaluating edge
  always @* begin
    toggled_nxt = 1'h0;
    trg_ignored_nxt = 1'h0;
    conflict_nxt = 1'h0;
    restored_nxt = 1'h0;
    case (state_r)
      ST_OFF: begin
        // nothing is evaluated while unpowered
        restored_nxt = 1'h0;
      end
      ST_RESTORE: begin
        // only a retained value counts as restored
        restored_nxt = power_ok_i & retain_en_i;
      end
      ST_RUN: begin
        if (run_eval) begin
          conflict_nxt = both_high;
          // the toggle only lands when neither set nor clear is up
          toggled_nxt = trg_gated & ~set_i & ~clear_i;
          // an edge arriving while set or clear is high has no effect
          trg_ignored_nxt = trg_gated & (set_i | clear_i);
        end
      end
      default: begin
        restored_nxt = 1'h0;
      end
    endcase
  end

  // state registers; reset is a cold start, which also clears the copy
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      restore_cnt_r <= 2'h0;
      q_r <= `TSR_Q_RESET;
      q_saved_r <= `TSR_Q_RESET;
      toggled_r <= 1'h0;
      trg_ignored_r <= 1'h0;
      conflict_r <= 1'h0;
      restored_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      restore_cnt_r <= restore_cnt_nxt;
      q_r <= q_nxt;
      q_saved_r <= q_saved_nxt;
      toggled_r <= toggled_nxt;
      trg_ignored_r <= trg_ignored_nxt;
      conflict_r <= conflict_nxt;
      restored_r <= restored_nxt;
    end
  end

  // outputs straight from flops, running_o decoded from state_r, so downstream blocks see no glitches
  assign q_o = q_r;
  assign q_n_o = ~q_r;
  assign running_o = (state_r == ST_RUN);
  assign toggled_o = toggled_r;
  assign trg_ignored_o = trg_ignored_r;
  assign conflict_o = conflict_r;
  assign restored_o = restored_r;

endmodule // tsr_top

`default_nettype wire

// *** bench/tsr_src.sv ***
// upstream logic blocks feeding trigger, set and clear levels
`timescale 1ns/1ps
`default_nettype none
module tsr_src (
  // levels asked for by the bench
  input wire logic [2:0] req_i,
  // levels seen by the cell
  output logic trg_o,
  output logic set_o,
  output logic clear_o
);
  // plain levels, as other program blocks present them each cycle
  assign {trg_o, set_o, clear_o} = req_i;
endmodule // tsr_src
`default_nettype wire

// *** bench/tsr_chk.sv ***
// assertion checker for the toggling set/clear cell
`timescale 1ns/1ps
`default_nettype none
module tsr_chk (
  input wire logic clk_i, rst_n_i, trg_i, set_i, clear_i, prio_sel_i, mode_sel_i,
  input wire logic retain_en_i, power_ok_i, q_o, q_n_o, running_o, toggled_o,
  input wire logic trg_ignored_o, conflict_o, restored_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // an edge only counts while running and powered
  wire logic ev = running_o && power_ok_i;
  AST_TOGGLE:
    assert property (ev && !mode_sel_i && !set_i && !clear_i && trg_i && !$past(trg_i)
      |=> q_o != $past(q_o) && toggled_o) else $error("trigger did not toggle");
  AST_MASK:
    assert property (ev && !mode_sel_i && (set_i || clear_i) && trg_i && !$past(trg_i)
      |=> trg_ignored_o && !toggled_o) else $error("masked trigger acted");
  AST_SET:
    assert property (ev && set_i && !clear_i |=> q_o) else $error("set did not drive high");
  AST_CLEAR:
    assert property (ev && clear_i && !set_i |=> !q_o) else $error("clear did not drive low");
  AST_BOTH:
    assert property (ev && set_i && clear_i
      |=> q_o == ($past(prio_sel_i) && !$past(mode_sel_i)) && conflict_o)
      else $error("wrong winner with both high");
  AST_HOLD:
    assert property (ev && !set_i && !clear_i && (mode_sel_i || !trg_i || $past(trg_i))
      |=> $stable(q_o)) else $error("output moved without cause");
  AST_OFF:
    assert property (!power_ok_i |=> !q_o && !running_o) else $error("output alive unpowered");
  AST_RESTORE:
    assert property (restored_o |-> running_o && $past(retain_en_i))
      else $error("restore without retention");
endmodule // tsr_chk
bind tsr_top tsr_chk tsr_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .trg_i(trg_i),
  .set_i(set_i), .clear_i(clear_i), .prio_sel_i(prio_sel_i), .mode_sel_i(mode_sel_i),
  .retain_en_i(retain_en_i), .power_ok_i(power_ok_i), .q_o(q_o), .q_n_o(q_n_o),
  .running_o(running_o), .toggled_o(toggled_o), .trg_ignored_o(trg_ignored_o),
  .conflict_o(conflict_o), .restored_o(restored_o));
`default_nettype wire

// *** bench/tsr_top_tb.sv ***
// self-checking bench for the toggling set/clear cell
`timescale 1ns/1ps
`default_nettype none
module tsr_top_tb;
  logic clk = 0, rst_n = 0, prio = 0, mode = 0, ret = 0, pwr = 1, qm = 0, tp = 0, e;
  logic [2:0] req = 0;
  wire trg, st, cl, q, qn, run, rs;
  int fails = 0, checks = 0, k;
  logic exq[$];
  always #2 clk = ~clk;
  tsr_src tsr_src_inst (.req_i(req), .trg_o(trg), .set_o(st), .clear_o(cl));
  tsr_top tsr_top_inst (.clk_i(clk), .rst_n_i(rst_n), .trg_i(trg), .set_i(st), .clear_i(cl),
    .prio_sel_i(prio), .mode_sel_i(mode), .retain_en_i(ret), .power_ok_i(pwr), .q_o(q),
    .q_n_o(qn), .running_o(run), .toggled_o(), .trg_ignored_o(), .conflict_o(), .restored_o(rs));
  task automatic chk(input string n, input logic s, input logic x);
    checks++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", n, x, s);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait for the cell to reach normal evaluation
  task automatic wait_run();
    for (k = 0; k < 20 && run !== 1'b1; k++) @(negedge clk);
    if (run !== 1'b1) begin
      fails++;
      results();
    end
  endtask
  // model the next output, apply levels, note the expectation
  task automatic step(input logic t, s, c, p, m);
    req = {t, s, c};
    prio = p;
    mode = m;
    if (s && c) qm = p && !m; // latch mode ignores the priority select
    else if (c || s) qm = s;
    else if (t && !tp && !m) qm = !qm;
    tp = t;
    exq.push_back(qm);
    @(negedge clk);
  endtask
  // supply drops a few cycles, then returns with retention chosen
  task automatic cycle_power(input logic r);
    pwr = 0;
    ret = r;
    repeat (3) @(negedge clk);
    chk("q_o off", q, 1'b0);
    chk("running_o off", run, 1'b0);
    pwr = 1;
    wait_run();
    if (!r) qm = 0;
    chk("q_o back", q, qm);
    chk("restored_o", rs, r);
  endtask
  // compare each note once its evaluating edge has landed
  always @(posedge clk) begin
    #1;
    if (exq.size() > 0) begin
      e = exq.pop_front();
      chk("q_o", q, e);
      chk("q_n_o", qn, !e);
    end
  end
  initial begin
    void'($urandom(32'he351));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    wait_run();
    // every level combination after a quiet cycle, both priorities and modes
    for (int i = 0; i < 32; i++) begin
      step(0, 0, 0, i[3], i[4]);
      step(i[0], i[1], i[2], i[3], i[4]);
    end
    $display("test table done");
    repeat (400) step($urandom % 2 == 1, $urandom % 4 == 0, $urandom % 4 == 0,
      $urandom % 2 == 1, $urandom % 4 == 0);
    $display("test random done");
    step(0, 1, 0, 0, 0);
    cycle_power(1);
    cycle_power(0);
    step(1, 0, 0, 0, 0);
    step(0, 0, 0, 0, 0);
    $display("test power done");
    results();
  end
endmodule // tsr_top_tb
`default_nettype wire
